// *** hw/dlc_defs.vh ***
// Constants for the deserializer link output control block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef DLC_DEFS_VH
`define DLC_DEFS_VH

// Register offsets, 8-bit plain register port
`define DLC_ADDR_GENERAL 8'h02
`define DLC_ADDR_CONFIG 8'h03
`define DLC_ADDR_STATUS 8'h1C
`define DLC_ADDR_ERRCNT 8'h41

// Field positions
`define DLC_GEN_OSC_EN 5
`define DLC_GEN_OSC_SEL_HI 1
`define DLC_CFG_OEN 0
`define DLC_CFG_OSS 1
`define DLC_CFG_EDGE 2
`define DLC_CFG_LFM 3
`define DLC_CFG_RPT 4
`define DLC_CFG_BC 5
`define DLC_CFG_I2SB 6
`define DLC_CFG_REGSRC 7

// Reset values
`define DLC_GENERAL_RST 8'h00
`define DLC_CONFIG_RST 8'h07

// Timing
`define DLC_CLK_MHZ 100
`define DLC_STOP_NS 1000
// Stop time in system clocks, 1000 ns at 100 MHz, sized for the counter
`define DLC_STOP_CYC 8'h64
`define DLC_LOCK_EDGES 5'h10
`define DLC_ERR_MAX 5'h1F

// Oscillator half periods in system clocks
`define DLC_OSC_HALF0 5'h02
`define DLC_OSC_HALF1 5'h04
`define DLC_OSC_HALF2 5'h08
`define DLC_OSC_HALF3 5'h10

// Strap ratio thresholds, ratio scaled by 256
`define DLC_THR_2 8'h0F
`define DLC_THR_3 8'h23
`define DLC_THR_4 8'h32
`define DLC_THR_5 8'h47
`define DLC_THR_6 8'h5B
`define DLC_THR_7 8'h72
`define DLC_THR_8 8'h89
`define DLC_THR_9 8'h9B

// Strap codes
`define DLC_CODE_BC 4'h9

`endif

// *** hw/dlc_sync.v ***
// Three-stage synchroniser for a vector of pin inputs.
// Output moves only when stages two and three agree; runs on clk_i.
`timescale 1ns/10ps
module dlc_sync #(
	parameter W = 1
) (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire [W-1:0] async_i,
	input wire [W-1:0] reset_val_i,
	output reg [W-1:0] sync_o
);
	reg [W-1:0] stage1;
	reg [W-1:0] stage2;
	reg [W-1:0] stage3;
	genvar i;

	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk_i) begin
				if (rst_i) begin
					stage1[i] <= 1'b0;
					stage2[i] <= 1'b0;
					stage3[i] <= 1'b0;
					sync_o[i] <= 1'b0;
				end else if (ce_i) begin
					stage1[i] <= async_i[i];
					stage2[i] <= stage1[i];
					stage3[i] <= stage2[i];
					// Stage one is never looked at here
					if (stage2[i] == stage3[i])
						sync_o[i] <= stage3[i];
				end
			end
		end
	endgenerate

	// Reset constant only; input kept for a uniform port list
	wire unused_rv;
	assign unused_rv = |reset_val_i;
endmodule // dlc_sync

// *** hw/dlc_top.v ***
// Deserializer link output control: power-down, stop-stream sleep,
// relock, fault status, error count, oscillator clock, edge select,
// output-state matrix, strap decode, downstream interrupt forward.
// Assumes rx_* come from recovery logic on clk_i; pins are asynchronous.
// Behaviour
// - Power-down low disables device, all listed outputs undriven.
// - No embedded clock edges detected means stop, enter sleep.
// - Stream resuming after sleep relocks without any training pattern.
// - Sleep entry or exit leaves every configuration register intact.
// - Any of seven cable faults clears the cable-detected flag.
// - Link errors counted in a five-bit readable field.
// - Lost input, output enable one, select zero, oscillator enable set: oscillator pixel clock.
// - Edge select one launches data on rising edge, zero falling.
// - After power-down release, lock undriven or low until locked.
// - Lock output goes high once the lock sequence completes.
// - Output enable zero: lock driven once first locked, others low or undriven by select.
// - Enable one, input static: outputs low; select zero clock oscillator, select one pass holds.
// - Enable one, input active: lock high, outputs valid or low.
// - Low-frequency mode chooses 5-15 MHz range, default 15-85 MHz.
// - Downstream interrupt low is conveyed back over the link.
// - Configuration from register bit or decoded strap voltage ratio.
// - Codes 1-4 normal range, 5-8 low range, 9 backward compatible.
`timescale 1ns/10ps
`include "dlc_defs.vh"
module dlc_top (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire power_down_n_i,
	input wire serial_clk_i,
	input wire [6:0] link_fault_i,
	input wire link_error_i,
	input wire downstream_interrupt_in_n_i,
	input wire [7:0] mode_sel_ratio_i,
	input wire [23:0] rx_data_i,
	input wire [3:0] rx_gpio_i,
	input wire [3:0] rx_i2s_i,
	input wire rx_pass_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	output reg lock_o,
	output reg lock_oe_o,
	output reg pass_o,
	output reg pass_oe_o,
	output reg [23:0] data_o,
	output reg [3:0] gpio_o,
	output reg [3:0] i2s_o,
	output reg par_oe_o,
	output reg pclk_o,
	output reg pclk_oe_o,
	output reg sleep_o,
	output reg remote_int_n_o,
	output reg low_frequency_mode_o,
	output reg repeater_o,
	output reg backward_compat_o,
	output reg i2s_chan_b_o
);
	localparam ST_OFF = 2'b00;
	localparam ST_ACQ = 2'b01;
	localparam ST_LOCK = 2'b10;
	localparam ST_SLEEP = 2'b11;
	localparam [7:0] STOP_CYC = `DLC_STOP_CYC;

	// Synchronised pins
	wire [18:0] pin_sync;
	wire pd_n;
	wire s_clk;
	wire [6:0] fault;
	wire err_lvl;
	wire ds_int_n;
	wire [7:0] ratio;

	dlc_sync #(.W(19)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.async_i({mode_sel_ratio_i, downstream_interrupt_in_n_i,
			link_error_i, link_fault_i, serial_clk_i, power_down_n_i}),
		.reset_val_i(19'h00000),
		.sync_o(pin_sync)
	);
	assign pd_n = pin_sync[0];
	assign s_clk = pin_sync[1];
	assign fault = pin_sync[8:2];
	assign err_lvl = pin_sync[9];
	assign ds_int_n = pin_sync[10];
	assign ratio = pin_sync[18:11];

	// Registers
	reg [7:0] gen_reg;
	reg [7:0] cfg_reg;
	reg [4:0] err_cnt;
	reg link_ok;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [7:0] idle_cnt;
	reg [4:0] edge_cnt;
	reg s_clk_q;
	reg err_q;
	reg pd_q;
	reg ever_locked;
	reg [4:0] osc_cnt;
	reg osc_clk;
	reg [3:0] code;
	reg [4:0] osc_half;

	wire s_rise;
	wire s_fall;
	wire s_edge;
	wire launch;
	wire err_rise;
	wire pd_rise;
	wire locked;
	wire osc_en;
	wire output_enable_sel;
	wire oss;

	assign s_rise = s_clk & ~s_clk_q;
	assign s_fall = ~s_clk & s_clk_q;
	assign s_edge = s_rise | s_fall;
	assign launch = cfg_reg[`DLC_CFG_EDGE] ? s_rise : s_fall;
	assign err_rise = err_lvl & ~err_q;
	assign pd_rise = pd_n & ~pd_q;
	assign locked = (state == ST_LOCK);
	assign osc_en = gen_reg[`DLC_GEN_OSC_EN];
	assign output_enable_sel = cfg_reg[`DLC_CFG_OEN];
	assign oss = cfg_reg[`DLC_CFG_OSS];

	// Register writes; sleep never touches these
	always @(posedge clk_i) begin
		if (rst_i) begin
			gen_reg <= `DLC_GENERAL_RST;
			cfg_reg <= `DLC_CONFIG_RST;
		end else if (ce_i && wr_i) begin
			if (addr_i == `DLC_ADDR_GENERAL)
				gen_reg <= wdata_i;
			else if (addr_i == `DLC_ADDR_CONFIG)
				cfg_reg <= wdata_i;
		end
	end

	// Read data one cycle after the strobe
	always @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			if (!rd_i)
				rdata_o <= 8'h00;
			else if (addr_i == `DLC_ADDR_GENERAL)
				rdata_o <= gen_reg;
			else if (addr_i == `DLC_ADDR_CONFIG)
				rdata_o <= cfg_reg;
			else if (addr_i == `DLC_ADDR_STATUS)
				rdata_o <= {5'h00, sleep_o, locked, link_ok};
			else if (addr_i == `DLC_ADDR_ERRCNT)
				rdata_o <= {3'h0, err_cnt};
			else
				rdata_o <= 8'h00;
		end
	end

	// Cable fault status and error count
	always @(posedge clk_i) begin
		if (rst_i) begin
			link_ok <= 1'b0;
			err_cnt <= 5'h00;
			err_q <= 1'b0;
		end else if (ce_i) begin
			err_q <= err_lvl;
			link_ok <= pd_n & ~(|fault);
			// A new error beats a clearing read
			if (err_rise && rd_i && addr_i == `DLC_ADDR_ERRCNT)
				err_cnt <= 5'h01;
			else if (rd_i && addr_i == `DLC_ADDR_ERRCNT)
				err_cnt <= 5'h00;
			else if (err_rise && err_cnt != `DLC_ERR_MAX)
				err_cnt <= err_cnt + 5'h01;
		end
	end

	// Lock and sleep sequencing
	always @* begin
		next_state = state;
		case (state)
		ST_OFF: begin
			if (pd_n)
				next_state = ST_ACQ;
		end
		ST_ACQ: begin
			if (idle_cnt == STOP_CYC)
				next_state = ST_SLEEP;
			else if (s_edge && edge_cnt == `DLC_LOCK_EDGES)
				next_state = ST_LOCK;
		end
		ST_LOCK: begin
			if (idle_cnt == STOP_CYC)
				next_state = ST_SLEEP;
		end
		default: begin
			if (s_edge)
				next_state = ST_ACQ;
		end
		endcase
		if (!pd_n)
			next_state = ST_OFF;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_OFF;
			idle_cnt <= 8'h00;
			edge_cnt <= 5'h00;
			s_clk_q <= 1'b0;
			sleep_o <= 1'b0;
			ever_locked <= 1'b0;
		end else if (ce_i) begin
			state <= next_state;
			s_clk_q <= s_clk;
			// Follows the state so lock has already dropped
			sleep_o <= (state == ST_SLEEP);
			// Missing embedded clock edges mean a stopped stream
			if (s_edge || state == ST_OFF || state == ST_SLEEP)
				idle_cnt <= 8'h00;
			else if (idle_cnt != STOP_CYC)
				idle_cnt <= idle_cnt + 8'h01;
			if (next_state != ST_ACQ)
				edge_cnt <= 5'h00;
			else if (s_edge && edge_cnt != `DLC_LOCK_EDGES)
				edge_cnt <= edge_cnt + 5'h01;
			if (next_state == ST_OFF)
				ever_locked <= 1'b0;
			else if (next_state == ST_LOCK)
				ever_locked <= 1'b1;
		end
	end

	// Fallback oscillator, frequency from the general register
	always @* begin
		case (gen_reg[`DLC_GEN_OSC_SEL_HI:0])
		2'b00: osc_half = `DLC_OSC_HALF0;
		2'b01: osc_half = `DLC_OSC_HALF1;
		2'b10: osc_half = `DLC_OSC_HALF2;
		default: osc_half = `DLC_OSC_HALF3;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			osc_cnt <= 5'h00;
			osc_clk <= 1'b0;
		end else if (ce_i) begin
			if (!osc_en || !pd_n) begin
				osc_cnt <= 5'h00;
				osc_clk <= 1'b0;
			end else if (osc_cnt >= osc_half - 5'h01) begin
				osc_cnt <= 5'h00;
				osc_clk <= ~osc_clk;
			end else begin
				osc_cnt <= osc_cnt + 5'h01;
			end
		end
	end

	// Strap ratio to discrete code
	always @* begin
		if (ratio < `DLC_THR_2)
			code = 4'h1;
		else if (ratio < `DLC_THR_3)
			code = 4'h2;
		else if (ratio < `DLC_THR_4)
			code = 4'h3;
		else if (ratio < `DLC_THR_5)
			code = 4'h4;
		else if (ratio < `DLC_THR_6)
			code = 4'h5;
		else if (ratio < `DLC_THR_7)
			code = 4'h6;
		else if (ratio < `DLC_THR_8)
			code = 4'h7;
		else if (ratio < `DLC_THR_9)
			code = 4'h8;
		else
			code = `DLC_CODE_BC;
	end

	// Mode settings latch at power-down release only, so a changed
	// low-frequency mode needs a power-down pulse to take effect
	always @(posedge clk_i) begin
		if (rst_i) begin
			pd_q <= 1'b0;
			low_frequency_mode_o <= 1'b0;
			repeater_o <= 1'b0;
			backward_compat_o <= 1'b0;
			i2s_chan_b_o <= 1'b0;
		end else if (ce_i) begin
			pd_q <= pd_n;
			if (pd_rise && cfg_reg[`DLC_CFG_REGSRC]) begin
				backward_compat_o <= cfg_reg[`DLC_CFG_BC];
				// Backward mode forces the normal range
				low_frequency_mode_o <= cfg_reg[`DLC_CFG_LFM] &
					~cfg_reg[`DLC_CFG_BC];
				repeater_o <= cfg_reg[`DLC_CFG_RPT];
				i2s_chan_b_o <= cfg_reg[`DLC_CFG_I2SB];
			end else if (pd_rise) begin
				backward_compat_o <= (code == `DLC_CODE_BC);
				low_frequency_mode_o <= (code >= 4'h5) &&
					(code != `DLC_CODE_BC);
				repeater_o <= (code == 4'h3) || (code == 4'h4) ||
					(code == 4'h7) || (code == 4'h8);
				i2s_chan_b_o <= (code != `DLC_CODE_BC) &&
					!code[0];
			end
		end
	end

	// Downstream interrupt level goes straight back over the link;
	// the far end rearms on the next falling edge
	always @(posedge clk_i) begin
		if (rst_i)
			remote_int_n_o <= 1'b1;
		else if (ce_i)
			remote_int_n_o <= pd_n ? ds_int_n : 1'b1;
	end

	// Output-state matrix
	always @(posedge clk_i) begin
		if (rst_i) begin
			lock_o <= 1'b0;
			lock_oe_o <= 1'b0;
			pass_o <= 1'b0;
			pass_oe_o <= 1'b0;
			data_o <= 24'h000000;
			gpio_o <= 4'h0;
			i2s_o <= 4'h0;
			par_oe_o <= 1'b0;
			pclk_o <= 1'b0;
			pclk_oe_o <= 1'b0;
		end else if (ce_i) begin
			lock_o <= locked;
			if (!pd_n) begin
				lock_oe_o <= 1'b0;
				pass_oe_o <= 1'b0;
				par_oe_o <= 1'b0;
				pclk_oe_o <= 1'b0;
				pass_o <= 1'b0;
				data_o <= 24'h000000;
				gpio_o <= 4'h0;
				i2s_o <= 4'h0;
				pclk_o <= 1'b0;
			end else if (!output_enable_sel) begin
				// Lock floats until the first lock after release
				lock_oe_o <= ever_locked;
				pass_oe_o <= ~oss;
				par_oe_o <= ~oss;
				pclk_oe_o <= ~oss;
				pass_o <= 1'b0;
				data_o <= 24'h000000;
				gpio_o <= 4'h0;
				i2s_o <= 4'h0;
				pclk_o <= 1'b0;
			end else if (!locked) begin
				lock_oe_o <= 1'b1;
				pass_oe_o <= 1'b1;
				par_oe_o <= 1'b1;
				pclk_oe_o <= 1'b1;
				if (!oss)
					pass_o <= 1'b0;
				data_o <= 24'h000000;
				gpio_o <= 4'h0;
				i2s_o <= 4'h0;
				pclk_o <= ~oss & osc_en & osc_clk;
			end else begin
				lock_oe_o <= 1'b1;
				pass_oe_o <= 1'b1;
				par_oe_o <= 1'b1;
				pclk_oe_o <= 1'b1;
				pclk_o <= oss & s_clk;
				if (!oss) begin
					pass_o <= 1'b0;
					data_o <= 24'h000000;
					gpio_o <= 4'h0;
					i2s_o <= 4'h0;
				end else if (launch) begin
					pass_o <= rx_pass_i;
					data_o <= rx_data_i;
					gpio_o <= rx_gpio_i;
					i2s_o <= rx_i2s_i;
				end
			end
		end
	end
endmodule // dlc_top

// *** tb/dlc_top_sva.sv ***
// Port-level assertions for the link output control block.
// Bound into dlc_top; assumes ce_i is held high by the bench.
`timescale 1ns/10ps
`include "dlc_defs.vh"
module dlc_top_chk (
	input wire clk_i,
	input wire rst_i,
	input wire power_down_n_i,
	input wire downstream_interrupt_in_n_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	input wire lock_o,
	input wire lock_oe_o,
	input wire pass_oe_o,
	input wire [23:0] data_o,
	input wire par_oe_o,
	input wire pclk_o,
	input wire pclk_oe_o,
	input wire sleep_o,
	input wire remote_int_n_o,
	input wire low_frequency_mode_o,
	input wire backward_compat_o
);
	reg [7:0] cfg_s;
	reg [2:0] quiet;
	wire cfg_wr = wr_i && addr_i == `DLC_ADDR_CONFIG;
	// Matrix checks wait for pins and config to settle through sync
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_s <= `DLC_CONFIG_RST;
			quiet <= 3'h0;
		end else begin
			if (cfg_wr)
				cfg_s <= wdata_i;
			if (cfg_wr || !power_down_n_i)
				quiet <= 3'h0;
			else if (quiet != 3'h7)
				quiet <= quiet + 3'h1;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_PD_OFF: assert property (
		!power_down_n_i [*6] |-> !(lock_oe_o || pass_oe_o || par_oe_o || pclk_oe_o))
		else $error("output driven in power-down");
	AST_CFG_READ: assert property (
		rd_i && addr_i == `DLC_ADDR_CONFIG |=> rdata_o == $past(cfg_s))
		else $error("config readback differs");
	AST_OSS_Z: assert property (
		quiet == 3'h7 && !cfg_s[0] && cfg_s[1] |-> !par_oe_o && !pclk_oe_o)
		else $error("outputs driven with select one");
	AST_OSS_LOW: assert property (
		quiet == 3'h7 && cfg_s[1:0] == 2'b00 |-> par_oe_o && data_o == 24'h0
		&& !pclk_o)
		else $error("outputs not low with select zero");
	AST_STATIC_LOW: assert property (
		quiet == 3'h7 && cfg_s[0] && !lock_o && !$past(lock_o)
		|-> par_oe_o && data_o == 24'h0)
		else $error("data not low while unlocked");
	AST_ACTIVE_VALID: assert property (
		quiet == 3'h7 && cfg_s[1:0] == 2'b11 && lock_o
		|-> par_oe_o && pass_oe_o && pclk_oe_o)
		else $error("outputs not driven while locked");
	AST_INT_LOW: assert property (
		!downstream_interrupt_in_n_i [*6] |-> !remote_int_n_o)
		else $error("interrupt not forwarded");
	AST_SLEEP_LOCK: assert property (
		sleep_o |-> !lock_o)
		else $error("lock high during sleep");
	AST_BC_LFM: assert property (
		backward_compat_o |-> !low_frequency_mode_o)
		else $error("low-frequency mode with compat");
	AST_MODE_HOLD: assert property (
		power_down_n_i [*8] |-> $stable(low_frequency_mode_o)
		&& $stable(backward_compat_o))
		else $error("mode changed while powered");
endmodule // dlc_top_chk
bind dlc_top dlc_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.power_down_n_i(power_down_n_i),
	.downstream_interrupt_in_n_i(downstream_interrupt_in_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .lock_o(lock_o), .lock_oe_o(lock_oe_o),
	.pass_oe_o(pass_oe_o), .data_o(data_o), .par_oe_o(par_oe_o),
	.pclk_o(pclk_o), .pclk_oe_o(pclk_oe_o), .sleep_o(sleep_o),
	.remote_int_n_o(remote_int_n_o),
	.low_frequency_mode_o(low_frequency_mode_o),
	.backward_compat_o(backward_compat_o));

// *** tb/dlc_ser_model.sv ***
// Far-end serializer stand-in: makes the embedded link clock.
// Clock runs while run_i is high and rests low between frames.
`timescale 1ns/10ps
module dlc_ser_model (
	input wire run_i,
	output reg sclk_o
);
	initial sclk_o = 1'b0;
	// Bare clock only, no training pattern before relock
	always begin
		if (run_i) begin
			#62.5 sclk_o = ~sclk_o;
		end else begin
			sclk_o = 1'b0;
			@(posedge run_i);
		end
	end
endmodule // dlc_ser_model

// *** tb/dlc_top_test.sv ***
// Self-checking bench for dlc_top: pins, register port, link clock.
// Serializer model makes the link clock; ce_i stays high.
`timescale 1ns/10ps
`include "dlc_defs.vh"
module dlc_top_test;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg pd_n = 1'b0;
	reg run = 1'b0;
	reg [6:0] fault = 7'h00;
	reg lerr = 1'b0;
	reg dint_n = 1'b1;
	reg [7:0] ratio = 8'h00;
	reg [23:0] rxd = 24'h0;
	reg [3:0] rxg = 4'h0;
	reg [3:0] rxs = 4'h0;
	reg rxp = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [7:0] wdata = 8'h00;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg rd_d = 1'b0;
	reg p0;
	wire sclk, lock, lock_oe, pass_oe, par_oe, pclk, pclk_oe, rint_n;
	wire sleep, lfm, rep, bc, chb, pass;
	wire [3:0] gpio;
	wire [3:0] i2s;
	wire [7:0] rdata;
	wire [23:0] data;
	integer n_fail = 0;
	integer checks = 0;
	integer seed = 32'h58bc;
	integer i;
	integer k;
	reg [7:0] expq [$];

	dlc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.power_down_n_i(pd_n), .serial_clk_i(sclk), .link_fault_i(fault),
		.link_error_i(lerr), .downstream_interrupt_in_n_i(dint_n),
		.mode_sel_ratio_i(ratio), .rx_data_i(rxd), .rx_gpio_i(rxg),
		.rx_i2s_i(rxs), .rx_pass_i(rxp), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .lock_o(lock),
		.lock_oe_o(lock_oe), .pass_o(pass), .pass_oe_o(pass_oe),
		.data_o(data), .gpio_o(gpio), .i2s_o(i2s), .par_oe_o(par_oe),
		.pclk_o(pclk),
		.pclk_oe_o(pclk_oe), .sleep_o(sleep), .remote_int_n_o(rint_n),
		.low_frequency_mode_o(lfm), .repeater_o(rep),
		.backward_compat_o(bc), .i2s_chan_b_o(chb));
	dlc_ser_model ser_u (.run_i(run), .sclk_o(sclk));

	always #5 clk_i = ~clk_i;

	task chk(input [23:0] got, input [23:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	// Pin values are sampled mid-cycle, away from the launching edge
	task pin(input [23:0] got, input [23:0] exp);
		begin
			@(negedge clk_i);
			chk(got, exp);
			@(posedge clk_i);
		end
	endtask
	task wreg(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_i);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk_i);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [7:0] a, input [7:0] e);
		begin
			@(posedge clk_i);
			expq.push_back(e);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk_i);
			rd <= 1'b0;
		end
	endtask
	task wait_lock;
		begin
			for (i = 0; i < 800 && lock !== 1'b1; i = i + 1)
				@(posedge clk_i);
			pin({23'h0, lock}, 24'h1);
		end
	endtask
	task note(input string s);
		$display("done %0s", s);
	endtask
	task conclude;
		begin
			$display("checks %0d n_fail %0d", checks, n_fail);
			if (n_fail == 0 && checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	always @(posedge clk_i)
		rd_d <= rd;
	always @(negedge clk_i)
		if (rd_d)
			chk({16'h0, rdata}, {16'h0, expq.pop_front()});

	initial begin
		#200000;
		n_fail = n_fail + 1;
		conclude;
	end

	initial begin
		cyc(4);
		rst_i <= 1'b0;
		rreg(`DLC_ADDR_CONFIG, `DLC_CONFIG_RST);
		rreg(`DLC_ADDR_GENERAL, `DLC_GENERAL_RST);
		wreg(`DLC_ADDR_ERRCNT, 8'hFF);
		rreg(`DLC_ADDR_ERRCNT, 8'h00);
		rreg(8'h55, 8'h00);
		note("regs");
		// Last pass is code one so the link runs in the normal range
		for (k = 8; k >= 0; k = k - 1) begin
			pd_n <= 1'b0;
			ratio <= (k < 8) ? 8'(k * 20) : 8'hC0;
			cyc(8);
			pin({20'h0, lock_oe, pass_oe, par_oe, pclk_oe}, 24'h0);
			pd_n <= 1'b1;
			cyc(8);
			pin({20'h0, lfm, rep, bc, chb},
				(k < 8) ? {20'h0, k[2], k[1], 1'b0, k[0]} : 24'h2);
		end
		note("strap");
		wreg(`DLC_ADDR_GENERAL, 8'h20);
		wreg(`DLC_ADDR_CONFIG, 8'h01);
		cyc(10);
		i = 0;
		p0 = pclk;
		repeat (40) begin
			@(negedge clk_i);
			if (pclk !== p0)
				i = i + 1;
			p0 = pclk;
		end
		pin({23'h0, i >= 19 && i <= 21}, 24'h1);
		wreg(`DLC_ADDR_CONFIG, 8'h02);
		cyc(8);
		pin({22'h0, par_oe, pclk_oe}, 24'h0);
		wreg(`DLC_ADDR_CONFIG, 8'h00);
		cyc(8);
		pin({par_oe, data[22:0]}, 24'h800000);
		note("matrix");
		wreg(`DLC_ADDR_CONFIG, 8'h07);
		rxd <= $random(seed);
		rxg <= $random(seed);
		rxs <= $random(seed);
		rxp <= 1'b1;
		run <= 1'b1;
		cyc(3);
		pin({23'h0, lock}, 24'h0);
		wait_lock;
		cyc(40);
		pin(data, rxd);
		pin({15'h0, pass, gpio, i2s}, {15'h0, rxp, rxg, rxs});
		rreg(`DLC_ADDR_STATUS, 8'h03);
		wreg(`DLC_ADDR_CONFIG, 8'h03);
		cyc(40);
		pin(data, rxd);
		for (k = 0; k < 7; k = k + 1) begin
			fault <= 7'h01 << k;
			cyc(6);
			rreg(`DLC_ADDR_STATUS, 8'h02);
			fault <= 7'h00;
			cyc(6);
		end
		repeat (3) begin
			lerr <= 1'b1;
			cyc(4);
			lerr <= 1'b0;
			cyc(4);
		end
		rreg(`DLC_ADDR_ERRCNT, 8'h03);
		rreg(`DLC_ADDR_ERRCNT, 8'h00);
		dint_n <= 1'b0;
		cyc(6);
		pin({23'h0, rint_n}, 24'h0);
		dint_n <= 1'b1;
		cyc(6);
		pin({23'h0, rint_n}, 24'h1);
		note("link");
		wreg(`DLC_ADDR_CONFIG, 8'h47);
		run <= 1'b0;
		for (i = 0; i < 400 && sleep !== 1'b1; i = i + 1)
			@(posedge clk_i);
		rreg(`DLC_ADDR_STATUS, 8'h05);
		rreg(`DLC_ADDR_CONFIG, 8'h47);
		run <= 1'b1;
		wait_lock;
		rreg(`DLC_ADDR_STATUS, 8'h03);
		rreg(`DLC_ADDR_CONFIG, 8'h47);
		pd_n <= 1'b0;
		cyc(8);
		pin({20'h0, lock_oe, pass_oe, par_oe, pclk_oe}, 24'h0);
		note("sleep");
		conclude;
	end
endmodule // dlc_top_test
